// file: inc/ncd_cfg.svh
// Constants for the nibble core decode block: opcode rows, low-nibble codes, reset values, PC steps.
// Assumes inclusion from the decoder and core files only.
`ifndef NCD_CFG_SVH
`define NCD_CFG_SVH
`define NCD_ROW_MISC 4'h0
`define NCD_ROW_ADDI 4'h1
`define NCD_ROW_MOVL 4'h2
`define NCD_ROW_MOVH 4'h3
`define NCD_ROW_LDA 4'h5
`define NCD_ROW_STDIR 4'h6
`define NCD_ROW_LDDIR 4'h7
`define NCD_ROW_IND 4'h8
`define NCD_ROW_BR 4'h9
`define NCD_ROW_CJL 4'hA
`define NCD_ROW_CJM 4'hB
`define NCD_ROW_CJA 4'hC
`define NCD_ROW_CJD 4'hD
`define NCD_ROW_JMP 4'hE
`define NCD_ROW_CALL 4'hF
`define NCD_LO_CLRC 4'h0
`define NCD_LO_INCA 4'h1
`define NCD_LO_DECA 4'hF
`define NCD_LO_CLRA 4'h0
`define NCD_LO_ADDM 4'h8
`define NCD_LO_ADDCM 4'h9
`define NCD_LO_CLRF 4'h6
`define NCD_LO_SETF 4'h7
`define NCD_PC_RST 12'h000
`define NCD_NIB_RST 4'h0
`define NCD_PC_STEP2 12'h002
`define NCD_PC_STEP1 12'h001
`endif

// file: inc/ncd_pkg.sv
// Types shared by the nibble core decode files.
// Assumes ncd_cfg.svh is on the include path.
package ncd_pkg;
    typedef enum logic [3:0] {
        NCD_OP_NOP, NCD_OP_CLRC, NCD_OP_INCA, NCD_OP_DECA, NCD_OP_ADDI, NCD_OP_ADDM, NCD_OP_ADDCM,
        NCD_OP_LDA, NCD_OP_MOVL, NCD_OP_MOVH, NCD_OP_RDDIR, NCD_OP_WRDIR, NCD_OP_FLAG,
        NCD_OP_COMPARE_BRANCH_NOT_EQUAL, NCD_OP_JMP, NCD_OP_CALL
    } ncd_op_t;
    typedef struct packed {
        ncd_op_t op;
        logic [3:0] imm;
        logic [1:0] cmp_sel;
        logic flag_val;
        logic two_byte;
    } ncd_dec_t;
    typedef struct packed {
        logic [3:0] sum;
        logic carry;
    } ncd_sum_t;
endpackage

// file: core/ncd_adder.sv
// Nibble adder with carry in and carry out.
// Assumes operands come from logic on the same clock.
module ncd_adder (
    input wire logic [3:0] a_i,
    input wire logic [3:0] b_i,
    input wire logic c_i,
    output ncd_pkg::ncd_sum_t s_o
);
    import ncd_pkg::*;
    logic [4:0] total;
    assign total = {1'b0, a_i} + {1'b0, b_i} + {4'h0, c_i};
    assign s_o = {total[3:0], total[4]};
endmodule

// file: core/ncd_decoder.sv
// Opcode byte decoder for the nibble core.
// Assumes a full opcode byte is presented each execute cycle.
`include "ncd_cfg.svh"
module ncd_decoder (
    input wire logic [7:0] opcode_i,
    output ncd_pkg::ncd_dec_t dec_o
);
    import ncd_pkg::*;
    logic [3:0] hi;
    logic [3:0] lo;
    assign hi = opcode_i[7:4];
    assign lo = opcode_i[3:0];
    always_comb begin
        dec_o = '0;
        dec_o.op = NCD_OP_NOP;
        dec_o.imm = lo;
        case (hi)
            `NCD_ROW_MISC: begin
                if (lo == `NCD_LO_ADDM) begin
                    dec_o.op = NCD_OP_ADDM;
                end else if (lo == `NCD_LO_ADDCM) begin
                    dec_o.op = NCD_OP_ADDCM;
                end
            end
            `NCD_ROW_ADDI: begin
                if (lo == `NCD_LO_CLRC) begin
                    dec_o.op = NCD_OP_CLRC;
                end else if (lo == `NCD_LO_INCA) begin
                    dec_o.op = NCD_OP_INCA;
                end else if (lo == `NCD_LO_DECA) begin
                    dec_o.op = NCD_OP_DECA;
                end else begin
                    dec_o.op = NCD_OP_ADDI;
                end
            end
            `NCD_ROW_MOVL: dec_o.op = NCD_OP_MOVL;
            `NCD_ROW_MOVH: dec_o.op = NCD_OP_MOVH;
            `NCD_ROW_LDA: dec_o.op = NCD_OP_LDA;
            `NCD_ROW_STDIR: dec_o.op = NCD_OP_WRDIR;
            `NCD_ROW_LDDIR: dec_o.op = NCD_OP_RDDIR;
            `NCD_ROW_IND: begin
                if (lo == `NCD_LO_CLRF || lo == `NCD_LO_SETF) begin
                    dec_o.op = NCD_OP_FLAG;
                    dec_o.flag_val = lo[0];
                end
            end
            `NCD_ROW_CJL, `NCD_ROW_CJM, `NCD_ROW_CJA, `NCD_ROW_CJD: begin
                dec_o.op = NCD_OP_COMPARE_BRANCH_NOT_EQUAL;
                dec_o.cmp_sel = hi[1:0];
                dec_o.two_byte = 1'b1;
            end
            `NCD_ROW_JMP: begin
                dec_o.op = NCD_OP_JMP;
                dec_o.two_byte = 1'b1;
            end
            `NCD_ROW_CALL: begin
                dec_o.op = NCD_OP_CALL;
                dec_o.two_byte = 1'b1;
            end
            default: dec_o.op = NCD_OP_NOP;
        endcase
    end
endmodule

// file: core/ncd_core.sv
// Function
// - Row one operand adds to accumulator, carry overflow
// - 08 adds RAM at pointer, carry out
// - 09 adds RAM, accumulator and carry
// - Branch displacement is signed eight bit
// - Direct operand selects one of sixteen registers
// - Two bit field selects RAM nibble bit
// - Data pointer is high over low nibble
// - Stack pointer is high over low part
// - Jump and call targets are twelve bit
// - Flag ops index flag array by pointer low nibble
// - Direct read returns register or port value
// - Row one: 0 clear carry, 1 inc, F dec
// - Row five: 0 clears, others load immediate
// - Rows A-D compare-branch, E jump, F call
// - Compare-branch adds displacement after advancing two
//
// Execution core for the nibble microcontroller: fetch, decode, execute.
// Assumes program memory and RAM answer combinationally in the same cycle;
// special registers other than the pointer nibbles live outside and answer sfr_rdata_i.
`include "ncd_cfg.svh"
module ncd_core (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic [11:0] prog_addr_o,
    input wire logic [7:0] prog_data_i,
    output logic [7:0] ram_addr_o,
    input wire logic [3:0] ram_rdata_i,
    output logic [3:0] ram_wdata_o,
    output logic ram_we_o,
    output logic [3:0] sfr_addr_o,
    input wire logic [3:0] sfr_rdata_i,
    output logic [3:0] sfr_wdata_o,
    output logic sfr_we_o,
    output logic [15:0] flags_o,
    output logic [3:0] acc_o,
    output logic carry_o
);
    import ncd_pkg::*;

    typedef enum logic [1:0] {NCD_FETCH, NCD_OPER, NCD_PUSH} ncd_state_t;

    ncd_state_t state_r;
    logic [11:0] pc_r;
    logic [7:0] opcode_r;
    logic [3:0] acc_r;
    logic carry_r;
    logic [3:0] ptr_hi_r;
    logic [3:0] ptr_lo_r;
    logic [3:0] sp_hi_r;
    logic [3:0] sp_lo_r;
    logic [15:0] flags_r;
    logic [1:0] push_cnt_r;
    logic [11:0] ret_pc_r;
    logic [11:0] call_tgt_r;
    logic [3:0] sfr_addr_r;

    ncd_dec_t dec;
    ncd_sum_t add_res;
    logic [7:0] data_pointer;
    logic [7:0] stack_pointer;
    logic [7:0] stack_next;
    logic [3:0] add_b;
    logic add_cin;
    logic [3:0] cmp_a;
    logic [3:0] cmp_b;
    logic [11:0] pc_after;
    logic [11:0] rel_ext;
    logic [7:0] exec_byte;
    logic exec_now;
    logic [3:0] dir_read;
    logic bit_wr;
    logic [3:0] bit_data;
    logic [3:0] push_data;

    assign data_pointer = {ptr_hi_r, ptr_lo_r};
    assign stack_pointer = {sp_hi_r, sp_lo_r};
    assign stack_next = stack_pointer + 8'h01;

    // One byte opcodes execute in the fetch cycle; two byte forms wait for the operand byte
    assign exec_byte = (state_r == NCD_FETCH) ? prog_data_i : opcode_r;

    ncd_decoder u_dec (
        .opcode_i(exec_byte),
        .dec_o(dec)
    );

    // Pointer nibbles are kept here, so direct reads of them bypass the outside registers
    always_comb begin
        case (exec_byte[3:0])
            4'h0: dir_read = ptr_lo_r;
            4'h1: dir_read = ptr_hi_r;
            default: dir_read = sfr_rdata_i;
        endcase
    end

    always_comb begin
        add_b = 4'h0;
        add_cin = 1'b0;
        case (dec.op)
            NCD_OP_ADDI: add_b = dec.imm;
            NCD_OP_ADDM: add_b = ram_rdata_i;
            NCD_OP_ADDCM: begin
                add_b = ram_rdata_i;
                add_cin = carry_r;
            end
            NCD_OP_INCA: add_b = 4'h1;
            NCD_OP_DECA: add_b = 4'hF;
            default: add_b = 4'h0;
        endcase
    end

    ncd_adder u_add (
        .a_i(acc_r),
        .b_i(add_b),
        .c_i(add_cin),
        .s_o(add_res)
    );

    always_comb begin
        cmp_a = acc_r;
        cmp_b = dec.imm;
        case (dec.cmp_sel)
            2'h2: cmp_a = ptr_lo_r;
            2'h3: cmp_a = ram_rdata_i;
            2'h0: cmp_a = acc_r;
            default: begin
                cmp_a = acc_r;
                cmp_b = dir_read;
            end
        endcase
    end

    assign exec_now = (state_r == NCD_FETCH && !dec.two_byte) || (state_r == NCD_OPER);

    // Bit writes patch the nibble at the data pointer in place; the read comes back in the same cycle
    assign bit_wr = exec_now && exec_byte[7:4] == `NCD_ROW_IND && exec_byte[3];
    always_comb begin
        bit_data = ram_rdata_i;
        bit_data[exec_byte[1:0]] = exec_byte[2];
    end
    assign pc_after = pc_r + `NCD_PC_STEP1;
    assign rel_ext = {{4{prog_data_i[7]}}, prog_data_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= NCD_FETCH;
            opcode_r <= 8'h00;
            push_cnt_r <= 2'h0;
        end else begin
            case (state_r)
                NCD_FETCH: begin
                    opcode_r <= prog_data_i;
                    if (dec.two_byte) begin
                        state_r <= NCD_OPER;
                    end
                end
                NCD_OPER: begin
                    state_r <= (dec.op == NCD_OP_CALL) ? NCD_PUSH : NCD_FETCH;
                    push_cnt_r <= 2'h0;
                end
                NCD_PUSH: begin
                    push_cnt_r <= push_cnt_r + 2'h1;
                    if (push_cnt_r == 2'h2) begin
                        state_r <= NCD_FETCH;
                    end
                end
                default: state_r <= NCD_FETCH;
            endcase
        end
    end

    // Program counter; relative targets are taken from the address after the operand byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_r <= `NCD_PC_RST;
            ret_pc_r <= `NCD_PC_RST;
            call_tgt_r <= `NCD_PC_RST;
        end else if (state_r == NCD_OPER) begin
            case (dec.op)
                NCD_OP_COMPARE_BRANCH_NOT_EQUAL: pc_r <= (cmp_a != cmp_b) ? pc_after + rel_ext : pc_after;
                NCD_OP_JMP: pc_r <= {opcode_r[3:0], prog_data_i};
                NCD_OP_CALL: begin
                    ret_pc_r <= pc_after;
                    call_tgt_r <= {opcode_r[3:0], prog_data_i};
                end
                default: pc_r <= pc_after;
            endcase
        end else if (state_r == NCD_PUSH) begin
            if (push_cnt_r == 2'h2) begin
                pc_r <= call_tgt_r;
            end
        end else begin
            pc_r <= pc_after;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r <= `NCD_NIB_RST;
            carry_r <= 1'b0;
        end else if (exec_now) begin
            case (dec.op)
                NCD_OP_ADDI, NCD_OP_ADDM, NCD_OP_ADDCM: begin
                    acc_r <= add_res.sum;
                    carry_r <= add_res.carry;
                end
                NCD_OP_CLRC: carry_r <= 1'b0;
                NCD_OP_INCA, NCD_OP_DECA: acc_r <= add_res.sum;
                NCD_OP_LDA: acc_r <= dec.imm;
                NCD_OP_RDDIR: acc_r <= dir_read;
                NCD_OP_COMPARE_BRANCH_NOT_EQUAL: carry_r <= (cmp_a < cmp_b);
                default: acc_r <= acc_r;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_hi_r <= `NCD_NIB_RST;
            ptr_lo_r <= `NCD_NIB_RST;
        end else if (exec_now) begin
            if (dec.op == NCD_OP_MOVL || (dec.op == NCD_OP_WRDIR && dec.imm == 4'h0)) begin
                ptr_lo_r <= (dec.op == NCD_OP_MOVL) ? dec.imm : acc_r;
            end
            if (dec.op == NCD_OP_MOVH || (dec.op == NCD_OP_WRDIR && dec.imm == 4'h1)) begin
                ptr_hi_r <= (dec.op == NCD_OP_MOVH) ? dec.imm : acc_r;
            end
        end
    end

    // Stack pointer advances before each nibble is written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_hi_r <= `NCD_NIB_RST;
            sp_lo_r <= `NCD_NIB_RST;
        end else if (state_r == NCD_PUSH) begin
            {sp_hi_r, sp_lo_r} <= stack_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= 16'h0000;
        end else if (exec_now && dec.op == NCD_OP_FLAG) begin
            flags_r[ptr_lo_r] <= dec.flag_val;
        end
    end

    // Return address goes out low nibble first, one nibble per push cycle
    always_comb begin
        case (push_cnt_r)
            2'h0: push_data = ret_pc_r[3:0];
            2'h1: push_data = ret_pc_r[7:4];
            default: push_data = ret_pc_r[11:8];
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sfr_addr_r <= 4'h0;
        end else begin
            sfr_addr_r <= dec.imm;
        end
    end

    // Reads are combinational, so in the fetch cycle the direct read address comes from the fetched byte
    assign prog_addr_o = pc_r;
    assign sfr_addr_o = (state_r == NCD_FETCH) ? prog_data_i[3:0] : sfr_addr_r;
    // Strobes come from the executing cycle: a registered strobe would meet the next fetch's select lines
    assign ram_addr_o = (state_r == NCD_PUSH) ? stack_next : data_pointer;
    assign ram_wdata_o = (state_r == NCD_PUSH) ? push_data : bit_data;
    assign ram_we_o = (state_r == NCD_PUSH) || bit_wr;
    assign sfr_wdata_o = acc_r;
    assign sfr_we_o = exec_now && dec.op == NCD_OP_WRDIR && dec.imm > 4'h1;
    assign flags_o = flags_r;
    assign acc_o = acc_r;
    assign carry_o = carry_r;

    property p_addi;
        @(posedge clk_i) disable iff (rst_i)
        (exec_now && dec.op == NCD_OP_ADDI) |=>
            ({carry_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(exec_byte[3:0])});
    endproperty
    a_addi: assert property (p_addi) else $error("add immediate result wrong");

    property p_add_with_carry;
        @(posedge clk_i) disable iff (rst_i)
        (exec_now && dec.op == NCD_OP_ADDCM) |=>
            ({carry_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(ram_rdata_i)} + {4'h0, $past(carry_r)});
    endproperty
    a_add_with_carry: assert property (p_add_with_carry) else $error("add with carry wrong");

    property p_addm;
        @(posedge clk_i) disable iff (rst_i)
        (exec_now && dec.op == NCD_OP_ADDM) |=>
            ({carry_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(ram_rdata_i)});
    endproperty
    a_addm: assert property (p_addm) else $error("add memory wrong");

    property p_compare_branch_not_equal;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == NCD_OPER && dec.op == NCD_OP_COMPARE_BRANCH_NOT_EQUAL && cmp_a == cmp_b) |=> pc_r == $past(pc_r) + 12'h001;
    endproperty
    a_compare_branch_not_equal: assert property (p_compare_branch_not_equal) else $error("untaken compare branch pc wrong");

    property p_jmp;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == NCD_OPER && dec.op == NCD_OP_JMP) |=> pc_r == {$past(opcode_r[3:0]), $past(prog_data_i)};
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump target wrong");

    property p_lda;
        @(posedge clk_i) disable iff (rst_i)
        (exec_now && dec.op == NCD_OP_LDA) |=> acc_r == $past(exec_byte[3:0]);
    endproperty
    a_lda: assert property (p_lda) else $error("load immediate wrong");

    property p_clrc;
        @(posedge clk_i) disable iff (rst_i)
        (exec_now && dec.op == NCD_OP_CLRC) |=> !carry_r && $stable(acc_r);
    endproperty
    a_clrc: assert property (p_clrc) else $error("clear carry wrong");

    property p_call;
        @(posedge clk_i) disable iff (rst_i)
        (state_r == NCD_OPER && dec.op == NCD_OP_CALL) |=> ram_we_o [*3];
    endproperty
    a_call: assert property (p_call) else $error("call push missing");

    c_addi: cover property (@(posedge clk_i) disable iff (rst_i) exec_now && dec.op == NCD_OP_ADDI && add_res.carry);
    c_br: cover property (@(posedge clk_i) disable iff (rst_i) state_r == NCD_OPER && dec.op == NCD_OP_COMPARE_BRANCH_NOT_EQUAL);
    c_call: cover property (@(posedge clk_i) disable iff (rst_i) state_r == NCD_PUSH && push_cnt_r == 2'h2);
endmodule

// file: testbench/ncd_mem_model.sv
// Far-side model: program memory, nibble data RAM and special registers.
// Assumes the bench preloads the arrays by hierarchical reference while the core is in reset.
module ncd_mem_model (
    input wire logic clk_i,
    input wire logic [11:0] prog_addr_i,
    output logic [7:0] prog_data_o,
    input wire logic [7:0] ram_addr_i,
    output logic [3:0] ram_rdata_o,
    input wire logic [3:0] ram_wdata_i,
    input wire logic ram_we_i,
    input wire logic [3:0] sfr_addr_i,
    output logic [3:0] sfr_rdata_o,
    input wire logic [3:0] sfr_wdata_i,
    input wire logic sfr_we_i
);
    logic [7:0] prog_mem [0:4095];
    logic [3:0] ram_mem [0:255];
    logic [3:0] sfr_mem [0:15];

    // Answers in the same cycle, as the core expects
    assign prog_data_o = prog_mem[prog_addr_i];
    assign ram_rdata_o = ram_mem[ram_addr_i];
    // Port reads come from the same array, the bench sets them up front
    assign sfr_rdata_o = sfr_mem[sfr_addr_i];

    // Plain always so the bench may also write the arrays
    always @(posedge clk_i) begin
        if (ram_we_i) begin
            ram_mem[ram_addr_i] <= ram_wdata_i;
        end
        if (sfr_we_i) begin
            sfr_mem[sfr_addr_i] <= sfr_wdata_i;
        end
    end
endmodule

// file: testbench/nibble_cpu_instruction_decode_test.sv
// Self-checking bench for the nibble core: small programs run from the memory model.
// Assumes ncd_core and ncd_mem_model are compiled first; one 50 MHz clock.
module nibble_cpu_instruction_decode_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i;
    logic rst_i;
    logic [11:0] prog_addr_o;
    logic [7:0] prog_data_i;
    logic [7:0] ram_addr_o;
    logic [3:0] ram_rdata_i;
    logic [3:0] ram_wdata_o;
    logic ram_we_o;
    logic [3:0] sfr_addr_o;
    logic [3:0] sfr_rdata_i;
    logic [3:0] sfr_wdata_o;
    logic sfr_we_o;
    logic [15:0] flags_o;
    logic [3:0] acc_o;
    logic carry_o;
    int fail_count;
    int comparisons;

    ncd_core u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
        .ram_addr_o(ram_addr_o), .ram_rdata_i(ram_rdata_i), .ram_wdata_o(ram_wdata_o), .ram_we_o(ram_we_o),
        .sfr_addr_o(sfr_addr_o), .sfr_rdata_i(sfr_rdata_i), .sfr_wdata_o(sfr_wdata_o), .sfr_we_o(sfr_we_o),
        .flags_o(flags_o), .acc_o(acc_o), .carry_o(carry_o)
    );

    ncd_mem_model u_mem (
        .clk_i(clk_i), .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i),
        .ram_addr_i(ram_addr_o), .ram_rdata_o(ram_rdata_i), .ram_wdata_i(ram_wdata_o), .ram_we_i(ram_we_o),
        .sfr_addr_i(sfr_addr_o), .sfr_rdata_o(sfr_rdata_i), .sfr_wdata_i(sfr_wdata_o), .sfr_we_i(sfr_we_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Holds reset for 20 cycles, wipes the memories and checks the reset state
    task automatic hold_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        #1;
        for (int i = 0; i < 4096; i++) begin
            u_mem.prog_mem[i] = 8'h00;
        end
        for (int i = 0; i < 256; i++) begin
            u_mem.ram_mem[i] = 4'h0;
        end
        for (int i = 0; i < 16; i++) begin
            u_mem.sfr_mem[i] = 4'h0;
        end
        check_val({acc_o, prog_addr_o}, 16'h0000);
        check_val(carry_o, 16'h0000);
        check_val(flags_o, 16'h0000);
    endtask

    task automatic release_reset;
        @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    task automatic load(input logic [11:0] a, input logic [7:0] q[$]);
        foreach (q[i]) begin
            u_mem.prog_mem[a + 12'(i)] = q[i];
        end
    endtask

    // Bounded wait until the core fetches from the given address
    task automatic run_to(input logic [11:0] a);
        int n;
        n = 0;
        while (prog_addr_o !== a && n < 400) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, prog_addr_o, a);
            summarize();
        end
    endtask

    task automatic t_arith;
        hold_reset();
        load(12'h000, {8'h5F, 8'h13, 8'h10, 8'h11, 8'h1F, 8'h1F, 8'h50, 8'hE0, 8'h07});
        release_reset();
        run_to(12'h002);
        check_val({acc_o, carry_o}, {4'h2, 1'b1});
        run_to(12'h003);
        check_val({acc_o, carry_o}, {4'h2, 1'b0});
        run_to(12'h004);
        check_val({acc_o, carry_o}, {4'h3, 1'b0});
        run_to(12'h006);
        check_val({acc_o, carry_o}, {4'h1, 1'b0});
        run_to(12'h007);
        check_val(acc_o, 4'h0);
        $display("test arith done");
    endtask

    task automatic t_addm;
        hold_reset();
        load(12'h000, {8'h22, 8'h31, 8'h5A, 8'h08, 8'h09, 8'hE0, 8'h05});
        u_mem.ram_mem[8'h12] = 4'h9;
        release_reset();
        run_to(12'h003);
        check_val(ram_addr_o, 8'h12);
        run_to(12'h004);
        check_val({acc_o, carry_o}, {4'h3, 1'b1});
        run_to(12'h005);
        check_val({acc_o, carry_o}, {4'hD, 1'b0});
        $display("test add memory done");
    endtask

    // Not-taken forms for rows A..D, then a taken backward branch after a jump
    task automatic t_branch;
        hold_reset();
        load(12'h000, {8'h55, 8'h21, 8'h30, 8'hA1, 8'h7F, 8'hB5, 8'h7F, 8'hC5, 8'h7F, 8'hD4, 8'h7F});
        load(12'h00B, {8'hE1, 8'h20});
        load(12'h120, {8'hC7, 8'hF0});
        load(12'h112, {8'h5A, 8'hE1, 8'h13});
        u_mem.ram_mem[8'h01] = 4'h5;
        u_mem.sfr_mem[4] = 4'h5;
        release_reset();
        run_to(12'h00B);
        check_val({acc_o, carry_o}, {4'h5, 1'b0});
        run_to(12'h113);
        check_val({acc_o, carry_o}, {4'hA, 1'b1});
        $display("test branch done");
    endtask

    task automatic t_call;
        hold_reset();
        load(12'h000, {8'hE3, 8'hA7});
        load(12'h3A7, {8'hF2, 8'h34});
        load(12'h234, {8'hE2, 8'h34});
        release_reset();
        run_to(12'h234);
        // Pushes are done before the target is fetched; the spare edges only add margin
        repeat (3) @(posedge clk_i);
        #1;
        check_val({u_mem.ram_mem[1], u_mem.ram_mem[2], u_mem.ram_mem[3]}, 16'h09A3);
        check_val(acc_o, 4'h0);
        $display("test call done");
    endtask

    task automatic t_flags;
        hold_reset();
        load(12'h000, {8'h25, 8'h87, 8'h22, 8'h87, 8'h25, 8'h86, 8'h5B, 8'h67, 8'h8A, 8'h8F, 8'hE0, 8'h0A});
        u_mem.ram_mem[8'h05] = 4'h7;
        release_reset();
        run_to(12'h002);
        check_val(flags_o, 16'h0020);
        run_to(12'h00A);
        repeat (2) @(posedge clk_i);
        #1;
        check_val(flags_o, 16'h0004);
        check_val(u_mem.sfr_mem[7], 4'hB);
        check_val(u_mem.sfr_mem[0], 4'h0);
        check_val(u_mem.ram_mem[5], 4'hB);
        $display("test flags done");
    endtask

    initial begin
        fail_count = 0;
        comparisons = 0;
        rst_i = 1'b1;
        t_arith();
        t_addm();
        t_branch();
        t_call();
        t_flags();
        summarize();
    end
endmodule
